// File: logic/dac_port_pkg.sv
package dac_port_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int CODE_W = 12;
  localparam int NUM_CH = 4;
  localparam int BASE_W = 4;
  localparam int OFFS_W = 3;
  localparam logic [CODE_W-1:0] CODE_POS_FULL = 12'hfff;
  localparam logic [CODE_W-1:0] CODE_ZERO = 12'h800;
  localparam logic [CODE_W-1:0] CODE_NEG_FULL = 12'h000;
  localparam logic [CODE_W-1:0] CODE_RESET = 12'h800;
  localparam int LOOP_W = 11;
  localparam int ACK_HOLD_NS = 10;
  localparam int CLK_NS = 10;
  localparam int ACK_HOLD_CYC = (ACK_HOLD_NS + CLK_NS - 1) / CLK_NS;
endpackage

// File: logic/channel_if.sv
`timescale 1ns/1ns
`default_nettype none
interface channel_if;
  import dac_port_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data_host;
  logic data_host_oe;
  logic [DATA_W-1:0] data_dev;
  logic data_dev_oe;
  logic channel_module_reset_n;
  logic transfer_strobe_n;
  logic write_qualifier_n;
  logic transfer_ack_n;
  modport host (
    output addr, data_host, data_host_oe, channel_module_reset_n, transfer_strobe_n, write_qualifier_n,
    input data_dev, data_dev_oe, transfer_ack_n
  );
  modport dev (
    input addr, data_host, data_host_oe, channel_module_reset_n, transfer_strobe_n, write_qualifier_n,
    output data_dev, data_dev_oe, transfer_ack_n
  );
endinterface
`default_nettype wire

// File: logic/dac_write_port.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// RULE1: Answer one block of eight byte locations
// RULE2: Two locations per channel from jumper base
// RULE3: Low location writes code bits 7:0
// RULE4: High location writes code bits 11:8
// RULE5: Compare top four address lines to jumpers
// RULE6: Codes are offset binary, 800 is zero
// RULE7: Loop current only for codes 800 upward
// RULE8: Twelve-bit address, eight-bit two-way data
// RULE9: Four control lines: reset, strobe, write, ack
// RULE10: Handshake-completed asynchronous cycles, up to 2 MB/s
// RULE11: Host uses odd addresses via bridge
// RULE12: Channel k at 2k/2k+1; update on high
module dac_write_port
  import dac_port_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Jumpers
  input wire logic [BASE_W-1:0] i_base_jumper,
  // Channel
  channel_if.dev bus,
  // Converter outputs
  output logic [NUM_CH*CODE_W-1:0] o_code,
  output logic [NUM_CH-1:0] o_code_update,
  output logic [NUM_CH-1:0] o_loop_valid,
  output logic [NUM_CH*LOOP_W-1:0] o_loop_level
);
  typedef enum {S_IDLE, S_ACK} state_t;
  localparam int HI_W = CODE_W - DATA_W;

  // Slice of one channel's code
  function automatic logic [CODE_W-1:0] code_of(
    input logic [NUM_CH*CODE_W-1:0] codes,
    input int k
  );
    return codes[k*CODE_W +: CODE_W];
  endfunction

  // Top four lines match jumpers, middle lines zero
  function automatic logic block_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [BASE_W-1:0] base
  );
    logic base_match;
    logic window_match;
    base_match = addr[ADDR_W-1 -: BASE_W] == base; // RULE5
    window_match = addr[ADDR_W-BASE_W-1:OFFS_W] == '0; // RULE1
    return base_match && window_match;
  endfunction

  // Channel number from the location pair
  function automatic logic [1:0] channel_of(
    input logic [ADDR_W-1:0] addr
  );
    return addr[OFFS_W-1:1]; // RULE2 RULE12
  endfunction

  // Upper location of a pair
  function automatic logic is_high(
    input logic [ADDR_W-1:0] addr
  );
    return addr[0]; // RULE4 RULE12
  endfunction

  // Current defined from zero code upward
  function automatic logic loop_defined(
    input logic [CODE_W-1:0] code
  );
    return code >= CODE_ZERO; // RULE6 RULE7
  endfunction

  // Loop level counted from zero code
  function automatic logic [LOOP_W-1:0] loop_level(
    input logic [CODE_W-1:0] code
  );
    logic [CODE_W-1:0] above;
    above = code - CODE_ZERO; // RULE6
    return above[LOOP_W-1:0]; // RULE7
  endfunction

  state_t state;
  state_t next_state;
  logic ack;
  logic next_ack;
  logic [NUM_CH*CODE_W-1:0] input_reg;
  logic [NUM_CH*CODE_W-1:0] next_input_reg;
  logic [NUM_CH*CODE_W-1:0] next_code;
  logic [NUM_CH-1:0] next_update;
  logic [NUM_CH-1:0] next_loop_valid;
  logic [NUM_CH*LOOP_W-1:0] next_loop_level;
  logic module_reset;
  logic selected;
  logic take;
  logic take_write;
  logic low_write;
  logic high_write;
  logic [1:0] ch;
  logic hi;

  // Request decode
  assign module_reset = !bus.channel_module_reset_n; // RULE9
  assign selected = block_hit(bus.addr, i_base_jumper); // RULE1 RULE5
  assign ch = channel_of(bus.addr); // RULE2
  assign hi = is_high(bus.addr);
  assign take = state == S_IDLE && !bus.transfer_strobe_n && selected && !module_reset; // RULE9 RULE10
  assign take_write = take && !bus.write_qualifier_n;
  assign low_write = take_write && !hi; // RULE3
  assign high_write = take_write && hi; // RULE4

  // Handshake, ack held until strobe released
  always_comb begin
    next_state = state;
    next_ack = ack;
    case (state)
      S_IDLE: begin
        if (take) begin
          next_state = S_ACK;
          next_ack = 1'b1;
        end
      end
      S_ACK: begin
        if (bus.transfer_strobe_n) begin // RULE10
          next_state = S_IDLE;
          next_ack = 1'b0;
        end
      end
      default: begin
        next_state = S_IDLE;
        next_ack = 1'b0;
      end
    endcase
    if (module_reset) begin // RULE9
      next_state = S_IDLE;
      next_ack = 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= S_IDLE;
      ack <= 1'b0;
    end else begin
      state <= next_state;
      ack <= next_ack;
    end
  end

  // Input registers, output code loads on high byte
  always_comb begin
    next_input_reg = input_reg;
    next_code = o_code;
    next_update = '0;
    if (low_write) begin
      next_input_reg[ch*CODE_W +: DATA_W] = bus.data_host; // RULE3
    end
    if (high_write) begin
      next_input_reg[ch*CODE_W+DATA_W +: HI_W] = bus.data_host[HI_W-1:0]; // RULE4 RULE12
      next_code[ch*CODE_W +: CODE_W] = {bus.data_host[HI_W-1:0], input_reg[ch*CODE_W +: DATA_W]}; // RULE12
      next_update[ch] = 1'b1;
    end
    if (module_reset) begin // RULE9
      next_input_reg = {NUM_CH{CODE_RESET}};
      next_code = {NUM_CH{CODE_RESET}};
      next_update = {NUM_CH{1'b1}};
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      input_reg <= {NUM_CH{CODE_RESET}};
      o_code <= {NUM_CH{CODE_RESET}};
      o_code_update <= '0;
    end else begin
      input_reg <= next_input_reg;
      o_code <= next_code;
      o_code_update <= next_update;
    end
  end

  // Loop outputs follow the code being loaded
  always_comb begin
    next_loop_valid = '0;
    next_loop_level = '0;
    for (int k = 0; k < NUM_CH; k++) begin
      next_loop_valid[k] = loop_defined(code_of(next_code, k)); // RULE7
      next_loop_level[k*LOOP_W +: LOOP_W] = loop_level(code_of(next_code, k)); // RULE6 RULE7
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_loop_valid <= {NUM_CH{1'b1}};
      o_loop_level <= '0;
    end else begin
      o_loop_valid <= next_loop_valid;
      o_loop_level <= next_loop_level;
    end
  end

  // Write only card, reads acked with zero
  assign bus.transfer_ack_n = !ack; // RULE9
  assign bus.data_dev = '0; // RULE8
  assign bus.data_dev_oe = 1'b0;
endmodule // dac_write_port
`default_nettype wire

// File: logic/channel_host.sv
`timescale 1ns/1ns
`default_nettype none
module channel_host
  import dac_port_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // User request
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_module_reset,
  output logic o_busy,
  output logic o_done,
  output logic [DATA_W-1:0] o_rdata,
  // Channel
  channel_if.host bus
);
  typedef enum {H_IDLE, H_STROBE, H_RELEASE} hstate_t;
  hstate_t state, next_state;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [DATA_W-1:0] wdata, next_wdata, next_rdata;
  logic write, next_write, next_done;

  always_comb begin
    next_state = state;
    next_addr = addr;
    next_wdata = wdata;
    next_write = write;
    next_rdata = o_rdata;
    next_done = 1'b0;
    case (state)
      H_IDLE: begin
        if (i_req && !i_module_reset) begin
          next_state = H_STROBE;
          next_addr = i_addr; // RULE8 RULE11
          next_wdata = i_wdata;
          next_write = i_write;
        end
      end
      H_STROBE: begin
        if (!bus.transfer_ack_n) begin // RULE10
          next_state = H_RELEASE;
          if (!write) begin
            next_rdata = bus.data_dev;
          end
        end
      end
      H_RELEASE: begin
        if (bus.transfer_ack_n) begin
          next_state = H_IDLE;
          next_done = 1'b1;
        end
      end
      default: next_state = H_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= H_IDLE;
      addr <= '0;
      wdata <= '0;
      write <= 1'b0;
      o_rdata <= '0;
      o_done <= 1'b0;
    end else begin
      state <= next_state;
      addr <= next_addr;
      wdata <= next_wdata;
      write <= next_write;
      o_rdata <= next_rdata;
      o_done <= next_done;
    end
  end

  assign o_busy = state != H_IDLE;
  assign bus.addr = addr;
  assign bus.data_host = wdata;
  assign bus.data_host_oe = write && state != H_IDLE;
  assign bus.transfer_strobe_n = state != H_STROBE; // RULE9
  assign bus.write_qualifier_n = !(write && state != H_IDLE);
  assign bus.channel_module_reset_n = !i_module_reset;
endmodule // channel_host
`default_nettype wire

// File: sim/dac_port_properties.sv
`timescale 1ns/1ns
`default_nettype none
module dac_port_properties
  import dac_port_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [BASE_W-1:0] i_base_jumper,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic data_host_oe,
  input wire logic data_dev_oe,
  input wire logic channel_module_reset_n,
  input wire logic transfer_strobe_n,
  input wire logic write_qualifier_n,
  input wire logic transfer_ack_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic sel;
  logic go;
  assign sel = addr[11:8] == i_base_jumper && addr[7:3] == 5'h00;
  assign go = !transfer_strobe_n && channel_module_reset_n;
  a_ack_on_select: assert property ($fell(transfer_strobe_n) && sel && channel_module_reset_n |=> !transfer_ack_n)
    else $error("no ack");
  a_no_stray: assert property ($fell(transfer_ack_n) |-> $past(sel))
    else $error("stray ack");
  a_ack_stands: assert property (!transfer_ack_n && go |=> !transfer_ack_n)
    else $error("ack dropped");
  a_ack_release: assert property (!transfer_ack_n && transfer_strobe_n |=> transfer_ack_n)
    else $error("ack stuck");
  a_addr_held: assert property (go && transfer_ack_n |=> $stable(addr) && $stable(write_qualifier_n))
    else $error("addr moved");
  a_write_drives: assert property (!transfer_strobe_n && !write_qualifier_n |-> data_host_oe)
    else $error("data not driven");
  a_dev_quiet: assert property (data_dev_oe == 1'b0)
    else $error("device drives");
  a_mreset_idle: assert property (!channel_module_reset_n |=> transfer_ack_n)
    else $error("ack in reset");
  cover property (!transfer_ack_n && !write_qualifier_n);
  cover property (!transfer_ack_n && write_qualifier_n);
  cover property ($fell(channel_module_reset_n));
endmodule // dac_port_properties
`default_nettype wire

// File: sim/quad_dac_write_port_tb.sv
`timescale 1ns/1ns
`default_nettype none
module quad_dac_write_port_tb;
  import dac_port_pkg::*;
  logic i_clk = 0, i_rst = 1, rq = 0, wr = 0, mr = 0, dn;
  logic [11:0] ad = '0;
  logic [7:0] wd = '0, rd;
  logic [3:0] jmp = 4'ha, upd, lv, seen = '0;
  logic [47:0] code;
  logic [43:0] ll;
  logic [11:0] tbl [4] = '{12'hfff, 12'h800, 12'h000, 12'ha5c};
  int bad_count = 0, checks_done = 0;
  channel_if ch();
  dac_write_port dac_write_port_inst (.i_clk(i_clk), .i_rst(i_rst), .i_base_jumper(jmp), .bus(ch.dev),
    .o_code(code), .o_code_update(upd), .o_loop_valid(lv), .o_loop_level(ll));
  channel_host channel_host_inst (.i_clk(i_clk), .i_rst(i_rst), .i_req(rq), .i_write(wr), .i_addr(ad),
    .i_wdata(wd), .i_module_reset(mr), .o_busy(), .o_done(dn), .o_rdata(rd), .bus(ch.host));
  dac_port_properties dac_port_properties_inst (.i_clk(i_clk), .i_rst(i_rst), .i_base_jumper(jmp),
    .addr(ch.addr), .data_host_oe(ch.data_host_oe), .data_dev_oe(ch.data_dev_oe),
    .channel_module_reset_n(ch.channel_module_reset_n), .transfer_strobe_n(ch.transfer_strobe_n),
    .write_qualifier_n(ch.write_qualifier_n), .transfer_ack_n(ch.transfer_ack_n));
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) seen <= i_rst ? 4'h0 : (seen | upd);
  task results;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(string n, logic [63:0] e, logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[FAIL] %s exp %h got %h", n, e, g);
      bad_count++;
    end
  endtask
  task xfer(logic w, logic [11:0] a, logic [7:0] d);
    @(posedge i_clk);
    {rq, wr, ad, wd} <= {1'b1, w, a, d};
    @(posedge i_clk);
    rq <= 0;
    for (int i = 0; i < 20 && dn !== 1'b1; i++) @(posedge i_clk);
    if (dn !== 1'b1) begin
      bad_count++;
      results;
    end
  endtask
  task t_codes;
    for (int k = 0; k < 4; k++) begin
      xfer(1, {jmp, 5'h0, k[1:0], 1'b0}, tbl[k][7:0]);
      chk("low only", 12'h800, code[12*k +: 12]);
      xfer(1, {jmp, 5'h0, k[1:0], 1'b1}, {4'hb, tbl[k][11:8]});
      chk("code", tbl[k], code[12*k +: 12]);
      chk("loop", {tbl[k] >= CODE_ZERO, LOOP_W'(tbl[k] - CODE_ZERO)}, {lv[k], ll[11*k +: 11]});
    end
    chk("update", 4'hf, seen);
  endtask
  task t_read;
    xfer(0, {jmp, 8'h03}, 8'h00);
    chk("rdata", 8'h00, rd);
    chk("read keeps", CODE_ZERO, code[23:12]);
  endtask
  task t_mreset;
    mr <= 1;
    repeat (2) @(posedge i_clk);
    mr <= 0;
    repeat (3) @(posedge i_clk);
    chk("mreset", {4'hf, {4{CODE_ZERO}}}, {lv, code});
    chk("mreset loop", 44'h0, ll);
  endtask
  task t_unsel;
    {rq, wr, ad, wd} <= {1'b1, 1'b1, ~jmp, 8'h01, 8'h07};
    repeat (12) @(posedge i_clk);
    chk("unsel base", {1'b1, CODE_ZERO}, {ch.transfer_ack_n, code[11:0]});
    i_rst <= 1;
    ad <= {jmp, 8'h09};
    repeat (4) @(posedge i_clk);
    i_rst <= 0;
    repeat (12) @(posedge i_clk);
    chk("unsel offset", {1'b1, CODE_ZERO}, {ch.transfer_ack_n, code[11:0]});
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst <= 0;
    @(posedge i_clk);
    chk("reset", {4'hf, 48'h800800800800}, {lv, code});
    t_codes;
    t_read;
    t_mreset;
    t_unsel;
    results;
  end
endmodule // quad_dac_write_port_tb
`default_nettype wire
